// *** logic/sw_gc_pkg.sv ***
// Shared constants, field layout and carrier types for the switch global control block.
package sw_gc_pkg;

  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned FAST_AGE_US = 800;
  localparam int unsigned NORMAL_AGE_S = 300;
  localparam int unsigned AGE_CNT_W = 36;
  localparam logic [35:0] FAST_AGE_CYC = 36'(FAST_AGE_US * CLK_MHZ);
  localparam logic [35:0] NORMAL_AGE_CYC = 36'(64'(NORMAL_AGE_S) * 64'(CLK_MHZ) * 64'd1000000);

  localparam int unsigned NPORTS = 2;
  localparam int unsigned ADDR_W = 8;

  localparam logic [7:0] GC1_INDEX = 8'h02;
  localparam logic [7:0] GC1_ADDR = 8'(GC1_INDEX * 4);
  localparam logic [7:0] STATUS_ADDR = 8'h0c;

  localparam int unsigned PASS_ALL_BIT = 15;
  localparam int unsigned TX_FC_BIT = 13;
  localparam int unsigned RX_FC_BIT = 12;
  localparam int unsigned LEN_CHK_BIT = 11;
  localparam int unsigned AGE_EN_BIT = 10;
  localparam int unsigned FAST_AGE_BIT = 9;
  localparam int unsigned AGGR_BO_BIT = 8;
  localparam int unsigned PASS_FC_BIT = 5;
  localparam int unsigned BIG_PKT_BIT = 4;
  localparam int unsigned ING_FC_BIT = 3;
  localparam int unsigned LINK_AGE_BIT = 0;
  localparam logic [15:0] GC1_RESET = 16'h3410;

  localparam logic [15:0] LEN_TYPE_MAX = 16'h05dc;
  localparam logic [15:0] SMALL_PKT_MAX = 16'h07d0;
  localparam logic [15:0] BIG_PKT_MAX = 16'h0800;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    AGE_OFF = 3'h1,
    AGE_NORMAL = 3'h2,
    AGE_FAST = 3'h4
  } age_state_t;

  typedef struct packed {
    logic valid;
    logic bad;
    logic is_pause;
    logic over_limit;
    logic sniffed;
    logic [15:0] frame_len;
    logic [15:0] len_type;
    logic [15:0] payload_len;
  } frame_info_t;

  typedef struct packed {
    logic valid;
    logic forward;
    logic honor_pause;
    logic send_pause;
    logic [3:0] drop_cause;
  } frame_verdict_t;

endpackage

// *** logic/age_timer.sv ***
// Address-table age period timer with link-loss triggered fast passes.
`timescale 1ns/1ps
module age_timer #(
  parameter logic [35:0] FAST_CYC = sw_gc_pkg::FAST_AGE_CYC,
  parameter logic [35:0] NORMAL_CYC = sw_gc_pkg::NORMAL_AGE_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic age_en,
  input wire logic fast_en,
  input wire logic link_age_en,
  input wire logic [sw_gc_pkg::NPORTS-1:0] link_up,
  output logic age_tick,
  output logic flush_all,
  output logic trig_pending,
  output sw_gc_pkg::age_state_t age_state
);

  typedef struct packed {
    sw_gc_pkg::age_state_t state;
    logic [35:0] cnt;
    logic [sw_gc_pkg::NPORTS-1:0] link_prev;
    logic tick;
    logic flush;
    logic trig;
  } age_regs_t;

  age_regs_t s_q;
  age_regs_t s_d;

  always_comb begin
    logic any_fall;
    logic [35:0] period;
    any_fall = |(s_q.link_prev & ~link_up);
    period = NORMAL_CYC;
    s_d = s_q;
    s_d.link_prev = link_up;
    s_d.tick = 1'b0;
    s_d.flush = any_fall;
    if (!age_en) begin
      s_d.state = sw_gc_pkg::AGE_OFF;
      s_d.cnt = 36'h0;
    end else begin
      if (fast_en || s_q.trig) begin
        period = FAST_CYC;
        s_d.state = sw_gc_pkg::AGE_FAST;
      end else begin
        s_d.state = sw_gc_pkg::AGE_NORMAL;
      end
      if (s_q.cnt >= period - 36'h1) begin
        s_d.cnt = 36'h0;
        s_d.tick = 1'b1;
        s_d.trig = 1'b0;
      end else begin
        s_d.cnt = s_q.cnt + 36'h1;
      end
    end
    // A new link loss in the closing cycle of a pass re-arms the trigger.
    if (any_fall && link_age_en) begin
      s_d.trig = 1'b1;
      if (!s_q.trig) begin
        s_d.cnt = 36'h0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q.state <= sw_gc_pkg::AGE_NORMAL;
      s_q.cnt <= 36'h0;
      s_q.link_prev <= '0;
      s_q.tick <= 1'b0;
      s_q.flush <= 1'b0;
      s_q.trig <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign age_tick = s_q.tick;
  assign flush_all = s_q.flush;
  assign trig_pending = s_q.trig;
  assign age_state = s_q.state;

endmodule

// *** logic/switch_global_control_one.sv ***
// Global switch control register with AXI4-Lite access, frame admission policy and aging control.
// Function
// - Pass-all forwards bad frames, only while sniffing.
// - Transmit pause off: never emit pause frames.
// - Receive pause off: ignore received pause frames.
// - Length check drops mismatched short length fields.
// - Aging enable off stops all aging; the link-loss flush_all still fires.
// - Fast age uses 800 us period.
// - Aggressive half-duplex back-off when enabled.
// - Over ingress limit: pause or drop.
// - Large packets up to 2K, else 2000.
// - Pass flow control frames instead of filtering.
// - Link loss triggers fast aging pass.
// - After triggered pass return to normal period.
// - Any link loss ages out all addresses.
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
module switch_global_control_one #(
  parameter logic [35:0] FAST_CYC = sw_gc_pkg::FAST_AGE_CYC,
  parameter logic [35:0] NORMAL_CYC = sw_gc_pkg::NORMAL_AGE_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [sw_gc_pkg::ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [sw_gc_pkg::ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [sw_gc_pkg::NPORTS-1:0] link_up,
  input wire sw_gc_pkg::frame_info_t frame_in,
  output sw_gc_pkg::frame_verdict_t verdict,
  input wire logic [sw_gc_pkg::NPORTS-1:0] pause_req,
  output logic [sw_gc_pkg::NPORTS-1:0] pause_tx,
  output logic aggressive_backoff,
  output logic age_tick,
  output logic flush_all
);

  // Decodes a byte address into a register select; used by both bus paths.
  function automatic logic [1:0] reg_sel(input logic [sw_gc_pkg::ADDR_W-1:0] a);
    logic [1:0] sel;
    sel = 2'h0;
    if (a == sw_gc_pkg::GC1_ADDR) begin
      sel = 2'h1;
    end else if (a == sw_gc_pkg::STATUS_ADDR) begin
      sel = 2'h2;
    end
    return sel;
  endfunction

  typedef struct packed {
    logic [15:0] gc1;
    logic aw_held;
    logic [sw_gc_pkg::ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic b_valid;
    logic [1:0] b_resp;
    logic r_valid;
    logic [31:0] r_data;
    logic [1:0] r_resp;
    logic [sw_gc_pkg::NPORTS-1:0] link_s1;
    logic [sw_gc_pkg::NPORTS-1:0] link_s2;
    sw_gc_pkg::frame_verdict_t verdict;
    logic [sw_gc_pkg::NPORTS-1:0] pause_tx;
    logic [15:0] drop_count;
  } ctrl_regs_t;

  ctrl_regs_t s_q;
  ctrl_regs_t s_d;

  logic tick_w;
  logic flush_w;
  logic trig_w;
  sw_gc_pkg::age_state_t age_state_w;

  age_timer #(
    .FAST_CYC(FAST_CYC),
    .NORMAL_CYC(NORMAL_CYC)
  ) u_age (
    .aclk(aclk),
    .aresetn(aresetn),
    .age_en(s_q.gc1[sw_gc_pkg::AGE_EN_BIT]),
    .fast_en(s_q.gc1[sw_gc_pkg::FAST_AGE_BIT]),
    .link_age_en(s_q.gc1[sw_gc_pkg::LINK_AGE_BIT]),
    .link_up(s_q.link_s2),
    .age_tick(tick_w),
    .flush_all(flush_w),
    .trig_pending(trig_w),
    .age_state(age_state_w)
  );

  // Write path: address and data may arrive in either order; each is held until both are here.
  assign awready = !s_q.aw_held && !s_q.b_valid;
  assign wready = !s_q.w_held && !s_q.b_valid;
  // Only one read is outstanding; the address is refused while the answer waits.
  assign arready = !s_q.r_valid;

  always_comb begin
    logic aw_now;
    logic w_now;
    logic [sw_gc_pkg::ADDR_W-1:0] wa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic [15:0] gc;
    logic fwd;
    logic honor;
    logic send;
    logic [3:0] cause;
    logic [15:0] limit;
    aw_now = awvalid && awready;
    w_now = wvalid && wready;
    wa = s_q.aw_held ? s_q.aw_addr : awaddr;
    wd = s_q.w_held ? s_q.w_data : wdata;
    ws = s_q.w_held ? s_q.w_strb : wstrb;
    gc = s_q.gc1;
    fwd = 1'b1;
    honor = 1'b0;
    send = 1'b0;
    cause = 4'h0;
    limit = sw_gc_pkg::SMALL_PKT_MAX;
    s_d = s_q;

    // Link pins come from the PHYs; two flops before anything reads them.
    s_d.link_s1 = link_up;
    s_d.link_s2 = s_q.link_s1;

    if (aw_now) begin
      s_d.aw_held = 1'b1;
      s_d.aw_addr = awaddr;
    end
    if (w_now) begin
      s_d.w_held = 1'b1;
      s_d.w_data = wdata;
      s_d.w_strb = wstrb;
    end
    if ((s_q.aw_held || aw_now) && (s_q.w_held || w_now)) begin
      s_d.aw_held = 1'b0;
      s_d.w_held = 1'b0;
      s_d.b_valid = 1'b1;
      s_d.b_resp = sw_gc_pkg::RESP_OKAY;
      case (reg_sel(wa))
        2'h1: begin
          // Reserved bits are stored as written; software keeps them by read-modify-write.
          if (ws[0]) begin
            s_d.gc1[7:0] = wd[7:0];
          end
          if (ws[1]) begin
            s_d.gc1[15:8] = wd[15:8];
          end
        end
        2'h2: begin
          s_d.b_resp = sw_gc_pkg::RESP_OKAY;
        end
        default: begin
          s_d.b_resp = sw_gc_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (s_q.b_valid && bready) begin
      s_d.b_valid = 1'b0;
    end

    if (arvalid && arready) begin
      s_d.r_valid = 1'b1;
      s_d.r_resp = sw_gc_pkg::RESP_OKAY;
      case (reg_sel(araddr))
        2'h1: begin
          s_d.r_data = {16'h0, s_q.gc1};
        end
        2'h2: begin
          s_d.r_data = {s_q.drop_count, 8'h0, 1'b0, age_state_w, trig_w, 1'b0, s_q.link_s2};
        end
        default: begin
          s_d.r_data = 32'h0;
          s_d.r_resp = sw_gc_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_q.r_valid && rready) begin
      s_d.r_valid = 1'b0;
    end

    // Frame admission, one verdict per offered frame, a cycle later.
    if (frame_in.bad && !(gc[sw_gc_pkg::PASS_ALL_BIT] && frame_in.sniffed)) begin
      fwd = 1'b0;
      cause[0] = 1'b1;
    end
    if (gc[sw_gc_pkg::LEN_CHK_BIT] && (frame_in.len_type < sw_gc_pkg::LEN_TYPE_MAX)
        && (frame_in.len_type != frame_in.payload_len)) begin
      fwd = 1'b0;
      cause[1] = 1'b1;
    end
    if (gc[sw_gc_pkg::BIG_PKT_BIT]) begin
      limit = sw_gc_pkg::BIG_PKT_MAX;
    end
    if (frame_in.frame_len > limit) begin
      fwd = 1'b0;
      cause[2] = 1'b1;
    end
    if (frame_in.is_pause) begin
      honor = gc[sw_gc_pkg::RX_FC_BIT];
      if (!gc[sw_gc_pkg::PASS_FC_BIT]) begin
        fwd = 1'b0;
        cause[3] = 1'b1;
      end
    end
    if (frame_in.over_limit) begin
      if (gc[sw_gc_pkg::ING_FC_BIT]) begin
        send = gc[sw_gc_pkg::TX_FC_BIT];
      end else begin
        fwd = 1'b0;
        cause[2] = 1'b1;
      end
    end
    s_d.verdict.valid = frame_in.valid;
    s_d.verdict.forward = frame_in.valid && fwd;
    s_d.verdict.honor_pause = frame_in.valid && honor;
    s_d.verdict.send_pause = frame_in.valid && send;
    s_d.verdict.drop_cause = frame_in.valid ? cause : 4'h0;
    if (frame_in.valid && !fwd && (s_q.drop_count != 16'hffff)) begin
      s_d.drop_count = s_q.drop_count + 16'h1;
    end

    // Queue-driven pause requests never leave while transmit pause is off.
    s_d.pause_tx = gc[sw_gc_pkg::TX_FC_BIT] ? pause_req : '0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q.gc1 <= sw_gc_pkg::GC1_RESET;
      s_q.aw_held <= 1'b0;
      s_q.aw_addr <= '0;
      s_q.w_held <= 1'b0;
      s_q.w_data <= 32'h0;
      s_q.w_strb <= 4'h0;
      s_q.b_valid <= 1'b0;
      s_q.b_resp <= 2'h0;
      s_q.r_valid <= 1'b0;
      s_q.r_data <= 32'h0;
      s_q.r_resp <= 2'h0;
      s_q.link_s1 <= '0;
      s_q.link_s2 <= '0;
      s_q.verdict <= '0;
      s_q.pause_tx <= '0;
      s_q.drop_count <= 16'h0;
    end else begin
      s_q <= s_d;
    end
  end

  assign bvalid = s_q.b_valid;
  assign bresp = s_q.b_resp;
  assign rvalid = s_q.r_valid;
  assign rdata = s_q.r_data;
  assign rresp = s_q.r_resp;
  assign verdict = s_q.verdict;
  assign pause_tx = s_q.pause_tx;
  assign aggressive_backoff = s_q.gc1[sw_gc_pkg::AGGR_BO_BIT];
  assign age_tick = tick_w;
  assign flush_all = flush_w;

endmodule

// *** verif/gc1_checker_asserts.sv ***
// Checker of frame verdicts, pause gating and link-loss flushing against the written control value.
`timescale 1ns/1ps
module gc1_checker #(
  parameter logic [35:0] FAST_CYC = sw_gc_pkg::FAST_AGE_CYC,
  parameter logic [35:0] NORMAL_CYC = sw_gc_pkg::NORMAL_AGE_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] link_up,
  input wire sw_gc_pkg::frame_info_t frame_in,
  input wire sw_gc_pkg::frame_verdict_t verdict,
  input wire logic [1:0] pause_req,
  input wire logic [1:0] pause_tx,
  input wire logic age_tick,
  input wire logic flush_all
);
  logic [15:0] ctl_q;
  logic [15:0] ctl_d;
  logic [15:0] old_q;
  sw_gc_pkg::frame_info_t f;
  assign f = frame_in;
  // The mirror assumes address and data are taken at one edge, which is how the bench offers them.
  always_comb begin
    ctl_d = ctl_q;
    if (awvalid && awready && wvalid && wready && awaddr == sw_gc_pkg::GC1_ADDR) begin
      ctl_d[7:0] = wstrb[0] ? wdata[7:0] : ctl_q[7:0];
      ctl_d[15:8] = wstrb[1] ? wdata[15:8] : ctl_q[15:8];
    end
  end
  always_ff @(posedge aclk) begin
    ctl_q <= aresetn ? ctl_d : sw_gc_pkg::GC1_RESET;
    old_q <= ctl_q;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_bad_drop: assert property (f.valid && f.bad && !(ctl_q[15] && f.sniffed) |=> !verdict.forward)
    else $error("bad frame forwarded");
  a_tx_gate: assert property (pause_tx == ($past(pause_req) & {2{old_q[13]}}))
    else $error("pause output not gated");
  a_rx_honor: assert property (f.valid && f.is_pause |=> verdict.honor_pause == old_q[12])
    else $error("pause honour wrong");
  a_len_drop: assert property (f.valid && ctl_q[11] && f.len_type < sw_gc_pkg::LEN_TYPE_MAX &&
    f.len_type != f.payload_len |=> !verdict.forward && verdict.drop_cause[1])
    else $error("length mismatch kept");
  a_ingress_act: assert property (f.valid && f.over_limit |=>
    verdict.send_pause == (old_q[3] && old_q[13]) && (old_q[3] || !verdict.forward))
    else $error("ingress limit action wrong");
  a_size_drop: assert property (f.valid &&
    f.frame_len > (ctl_q[4] ? sw_gc_pkg::BIG_PKT_MAX : sw_gc_pkg::SMALL_PKT_MAX) |=> !verdict.forward)
    else $error("oversize frame kept");
  a_fc_filter: assert property (f.valid && f.is_pause && !ctl_q[5] |=> !verdict.forward)
    else $error("pause frame not filtered");
  a_flush_link: assert property (|($past(link_up) & ~link_up) |-> ##3 flush_all)
    else $error("link loss without flush");
  c_flush: cover property (flush_all);
  c_pass_all: cover property (f.valid && f.bad && f.sniffed && ctl_q[15]);
  c_fast_tick: cover property (age_tick && ctl_q[9]);
endmodule

bind switch_global_control_one gc1_checker #(.FAST_CYC(FAST_CYC), .NORMAL_CYC(NORMAL_CYC)) chk (
  .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .link_up, .frame_in, .verdict,
  .pause_req, .pause_tx, .age_tick, .flush_all
);

// *** verif/link_partner.sv ***
// Behavioural link partner: cable state of one port and a count of pause frames received.
`timescale 1ns/1ps
module link_partner (
  input wire logic aclk,
  input wire logic plugged,
  input wire logic pause_in,
  output logic link_up,
  output int unsigned pauses
);
  // The link pin is asynchronous to the switch, so it follows the cable at once.
  assign link_up = plugged;
  initial pauses = 0;
  always @(posedge aclk) begin
    if (pause_in === 1'b1) begin
      pauses <= pauses + 1;
    end
  end
endmodule

// *** verif/switch_global_control_one_tb.sv ***
// Self-checking bench for the switch global control block.
`timescale 1ns/1ps
module switch_global_control_one_tb;
  localparam int fast_n = 20;
  localparam int norm_n = 200;
  typedef struct packed {
    logic [15:0] ctl;
    logic [4:0] fl;
    logic [15:0] len;
    logic [15:0] lt;
    logic [4:0] ex;
  } row_t;
  localparam row_t rows [13] = '{
    '{16'h3410, 5'h18, 16'h0040, 16'h0800, 5'h01},
    '{16'hb410, 5'h19, 16'h0040, 16'h0800, 5'h10},
    '{16'hb410, 5'h18, 16'h0040, 16'h0800, 5'h01},
    '{16'h3c10, 5'h10, 16'h0040, 16'h0030, 5'h02},
    '{16'h3c10, 5'h10, 16'h0040, 16'h05dc, 5'h10},
    '{16'h3510, 5'h10, 16'h0800, 16'h0800, 5'h10},
    '{16'h3410, 5'h10, 16'h0801, 16'h0800, 5'h04},
    '{16'h3400, 5'h10, 16'h07d1, 16'h0800, 5'h04},
    '{16'h3400, 5'h10, 16'h07d0, 16'h0800, 5'h10},
    '{16'h3410, 5'h12, 16'h0040, 16'h0800, 5'h04},
    '{16'h3418, 5'h12, 16'h0040, 16'h0800, 5'h10},
    '{16'h3410, 5'h14, 16'h0040, 16'h8808, 5'h08},
    '{16'h0430, 5'h14, 16'h0040, 16'h8808, 5'h10}
  };
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic aggressive_backoff, age_tick, flush_all;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, link_up, pause_req, pause_tx, plugged, r;
  sw_gc_pkg::frame_info_t frame_in;
  sw_gc_pkg::frame_verdict_t verdict;
  int unsigned pauses [2];
  int err_total, comparisons, k, flushes;

  switch_global_control_one #(.FAST_CYC(36'(fast_n)), .NORMAL_CYC(36'(norm_n))) DUT (
    .aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .link_up, .frame_in,
    .verdict, .pause_req, .pause_tx, .aggressive_backoff, .age_tick, .flush_all
  );
  for (genvar i = 0; i < 2; i++) begin : g_lp
    link_partner lp (.aclk, .plugged(plugged[i]), .pause_in(pause_tx[i]), .link_up(link_up[i]), .pauses(pauses[i]));
  end

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (flush_all === 1'b1) begin
      flushes <= flushes + 1;
    end
  end

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Ready is looked at mid-cycle, where it is settled; the handshake then happens at the next rising edge.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] rs);
    logic ta, tw, tb;
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      rs = bresp;
      n++;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (!tb && n < 100);
    // A missing answer is a failure, not a silent return.
    if (!tb) err_total++;
    bready <= 1'b0;
    // One idle edge keeps a following call from raising bready in the same time step.
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    logic ta, tr;
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid;
      d = rdata;
      rs = rresp;
      n++;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
    end while (!tr && n < 100);
    if (!tr) err_total++;
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic gap(output int c);
    c = 0;
    do begin
      @(negedge aclk);
      c++;
    end while (age_tick !== 1'b1 && c < 400);
  endtask
  task automatic period(input logic [15:0] c, input int e);
    @(posedge aclk);
    wr(sw_gc_pkg::GC1_ADDR, {16'h0000, c}, 4'h3, r);
    gap(k);
    gap(k);
    cmp(k, e);
  endtask
  task automatic pulse();
    pause_req <= 2'b11;
    @(posedge aclk);
    pause_req <= 2'b00;
    repeat (2) @(posedge aclk);
  endtask
  task automatic finish_test();
    if (err_total == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    // About twenty times the expected run.
    #300000;
    err_total++;
    finish_test();
  end

  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'h0;
    frame_in = '0;
    pause_req = 2'b00;
    plugged = 2'b11;
    err_total = 0;
    comparisons = 0;
    flushes = 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(sw_gc_pkg::GC1_ADDR, v, r);
    cmp(v, 32'h00003410);
    wr(sw_gc_pkg::GC1_ADDR, 32'h0000ffff, 4'h1, r);
    wr(8'h40, 32'h0000ffff, 4'h3, r);
    cmp(r, sw_gc_pkg::RESP_SLVERR);
    rd(sw_gc_pkg::GC1_ADDR, v, r);
    cmp(v, 32'h000034ff);
    wr(sw_gc_pkg::GC1_ADDR, 32'h00003410, 4'h3, r);
    pulse();
    cmp(pauses[0] + pauses[1], 2);
    wr(sw_gc_pkg::GC1_ADDR, 32'h00001410, 4'h3, r);
    pulse();
    cmp(pauses[0] + pauses[1], 2);
    for (int i = 0; i < 13; i++) begin
      wr(sw_gc_pkg::GC1_ADDR, {16'h0000, rows[i].ctl}, 4'h3, r);
      frame_in <= sw_gc_pkg::frame_info_t'({rows[i].fl, rows[i].len, rows[i].lt, 16'h0032});
      @(posedge aclk);
      frame_in <= '0;
      @(negedge aclk);
      cmp({26'h0, verdict.valid, verdict.forward, verdict.drop_cause}, {26'h0, 1'b1, rows[i].ex});
      cmp({31'h0, aggressive_backoff}, {31'h0, rows[i].ctl[8]});
      @(posedge aclk);
    end
    period(16'h3410, norm_n);
    period(16'h3610, fast_n);
    period(16'h3010, 400);
    period(16'h3411, norm_n);
    @(posedge aclk);
    plugged <= 2'b10;
    gap(k);
    cmp(k < fast_n + 5, 1);
    gap(k);
    cmp(k, norm_n);
    cmp(flushes, 1);
    @(posedge aclk);
    plugged <= 2'b11;
    period(16'h3410, norm_n);
    @(posedge aclk);
    plugged <= 2'b01;
    gap(k);
    cmp(k > fast_n + 5, 1);
    cmp(flushes, 2);
    wr(sw_gc_pkg::GC1_ADDR, 32'h00000000, 4'h3, r);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(sw_gc_pkg::GC1_ADDR, v, r);
    cmp(v, 32'h00003410);
    finish_test();
  end
endmodule
